// File: design/clock_gating_and_main_osc_ctrl.sv
// clock gating control and main oscillator control with register port
// assumes one 200 MHz clock, synchronous reset, a master that never waits
//
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "clock_gating_cfg.svh"

// Contract
// - writing one to set register bit 0 enables the processor clock; zeros change nothing
// - host port set bit turns on both host port clocks; this block has a single hostPortClk gate, on bit 6
// - set register bit 7 turns on the device port clock
// - set register bits 8 to 11 enable the four programmable clock outputs
// - set register bit 16 enables the bus clock output
// - clear register bit 0 stops the processor clock, idling it; zeros do nothing
// - clear register uses the same bits and disables the named clocks
// - system status register reads one per enabled clock, zero per disabled
// - peripheral set register bits 2 to 31 enable peripheral clocks
// - bits of unimplemented peripherals have no effect
// - peripheral clear register bits 2 to 31 disable peripheral clocks
// - peripheral status register reads one per enabled peripheral clock
// - oscillator control bit 0 enables or disables the main oscillator
// - stable flag rises only after the programmed start-up time elapses
// - bypass bit 1 uses the external clock and sets stable at once
// - clearing both enable and bypass resets the stable flag
// - start-up count bits 8 to 15 give delay of count times 8 slow cycles
module clock_gating_and_main_osc_ctrl
  import clock_gating_pkg::*;
#(
  parameter logic [31:0] PERIPH_IMPL = `PER_VALID_MASK,
  parameter int SLOW_DIV = `SLOW_DIV_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire bus_req_s busReq,
  output logic [31:0] rdata,
  output clk_gates_s clkGates,
  output logic [31:0] periphClkEn,
  output logic mainOscEnable,
  output logic xtalBypass,
  output logic mainOscStable,
  output logic irq
);

  localparam int DIV_W = $clog2(SLOW_DIV + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SLOW_DIV - 1);

  // set and clear bits act only where implemented, clear beating set; the mask drops the rest
  function automatic logic [31:0] applyGate(
    input logic [31:0] cur,
    input logic [31:0] setBits,
    input logic [31:0] clrBits,
    input logic [31:0] valid
  );
    logic [31:0] res;
    res = (cur | (setBits & valid)) & ~(clrBits & valid);
    return res & valid;
  endfunction

  // decode a write strobe to one offset
  function automatic logic hit(
    input bus_req_s req,
    input logic [7:0] ofs
  );
    return req.wr && (req.addr == ofs);
  endfunction

  logic [31:0] sysEn_q;
  logic [31:0] sysEn_d;
  logic [31:0] perEn_q;
  logic [31:0] perEn_d;
  logic oscEn_q;
  logic oscByp_q;
  logic [7:0] oscCount_q;
  osc_state_e oscState_q;
  logic stable_q;
  logic stablePrev_q;
  logic [DIV_W-1:0] divCnt_q;
  logic slowTick_q;
  logic [10:0] startCnt_q;
  logic [10:0] startTarget;
  logic [1:0] irqStat_q;
  logic [1:0] irqMask_q;
  logic [1:0] irqEvents;
  logic [31:0] rdata_q;
  logic irq_q;

  // system clock gates: set and clear strobes are separate offsets
  always_comb begin
    sysEn_d = sysEn_q;
    if (hit(busReq, `OFS_SYS_EN)) begin
      // bits 0, 6, 7, 8..11, 16 in one masked set
      sysEn_d = applyGate(sysEn_q, busReq.wdata, 32'h0, `SYS_VALID_MASK);
    end else if (hit(busReq, `OFS_SYS_DIS)) begin
      // clearing bit 0 idles the processor until a set re-enables it
      sysEn_d = applyGate(sysEn_q, 32'h0, busReq.wdata, `SYS_VALID_MASK);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sysEn_q <= `SYS_STAT_RESET & `SYS_VALID_MASK;
    end else begin
      sysEn_q <= sysEn_d;
    end
  end

  // peripheral clock gates; unimplemented identifiers never store a one
  always_comb begin
    perEn_d = perEn_q;
    if (hit(busReq, `OFS_PER_EN)) begin
      perEn_d = applyGate(perEn_q, busReq.wdata, 32'h0, PERIPH_IMPL & `PER_VALID_MASK);
    end else if (hit(busReq, `OFS_PER_DIS)) begin
      perEn_d = applyGate(perEn_q, 32'h0, busReq.wdata, PERIPH_IMPL & `PER_VALID_MASK);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      perEn_q <= `PER_STAT_RESET;
    end else begin
      perEn_q <= perEn_d;
    end
  end

  // oscillator control register fields
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      // reset fields cut from the register's reset word on purpose
      oscEn_q <= 1'((`OSC_CTRL_RESET) >> `BIT_OSC_EN);
      oscByp_q <= 1'((`OSC_CTRL_RESET) >> `BIT_OSC_BYP);
      oscCount_q <= 8'((`OSC_CTRL_RESET) >> `OSC_CNT_LO);
    end else if (hit(busReq, `OFS_OSC_CTRL)) begin
      oscEn_q <= busReq.wdata[`BIT_OSC_EN];
      oscByp_q <= busReq.wdata[`BIT_OSC_BYP];
      oscCount_q <= busReq.wdata[`OSC_CNT_HI:`OSC_CNT_LO];
    end
  end

  // slow clock enable from a free divider; the start-up count ticks on it
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      divCnt_q <= '0;
      slowTick_q <= 1'b0;
    end else if (divCnt_q == DIV_LAST) begin
      divCnt_q <= '0;
      slowTick_q <= 1'b1;
    end else begin
      divCnt_q <= DIV_W'(divCnt_q + 1'b1);
      slowTick_q <= 1'b0;
    end
  end

  // count value times eight slow cycles
  assign startTarget = {oscCount_q, 3'b000};

  // start-up sequencer; a new count written mid-start applies at once
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      oscState_q <= OSC_OFF;
      startCnt_q <= 11'h000;
      stable_q <= 1'b0;
    end else begin
      case (oscState_q)
        OSC_OFF: begin
          startCnt_q <= 11'h000;
          stable_q <= 1'b0;
          // bypass wins if software breaks the exclusive use of the two bits
          if (oscByp_q) begin
            oscState_q <= OSC_BYPASSED;
          end else if (oscEn_q) begin
            oscState_q <= OSC_STARTING;
          end
        end
        OSC_STARTING: begin
          if (!oscEn_q && !oscByp_q) begin
            oscState_q <= OSC_OFF;
          end else if (oscByp_q) begin
            oscState_q <= OSC_BYPASSED;
          end else if (startCnt_q >= startTarget) begin
            // flag only after the full programmed delay
            stable_q <= 1'b1;
            oscState_q <= OSC_STABLE;
          end else if (slowTick_q) begin
            startCnt_q <= 11'(startCnt_q + 1'b1);
          end
        end
        OSC_STABLE: begin
          if (!oscEn_q && !oscByp_q) begin
            stable_q <= 1'b0;
            oscState_q <= OSC_OFF;
          end else if (oscByp_q) begin
            oscState_q <= OSC_BYPASSED;
          end
        end
        OSC_BYPASSED: begin
          // external clock needs no start-up time
          stable_q <= 1'b1;
          if (!oscEn_q && !oscByp_q) begin
            stable_q <= 1'b0;
            oscState_q <= OSC_OFF;
          end else if (!oscByp_q) begin
            stable_q <= 1'b0;
            startCnt_q <= 11'h000;
            oscState_q <= OSC_STARTING;
          end
        end
        default: begin
          oscState_q <= OSC_OFF;
        end
      endcase
    end
  end

  // edge history of the stable flag for interrupt events
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      stablePrev_q <= 1'b0;
    end else begin
      stablePrev_q <= stable_q;
    end
  end

  assign irqEvents[`IRQ_STABLE_UP] = stable_q && !stablePrev_q;
  assign irqEvents[`IRQ_STABLE_LOST] = !stable_q && stablePrev_q;

  // sticky status, write one to clear; an event in the clear cycle survives
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irqStat_q <= `IRQ_RESET;
    end else if (hit(busReq, `OFS_IRQ_STAT)) begin
      irqStat_q <= (irqStat_q & ~busReq.wdata[1:0]) | irqEvents;
    end else begin
      irqStat_q <= irqStat_q | irqEvents;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irqMask_q <= `IRQ_RESET;
    end else if (hit(busReq, `OFS_IRQ_MASK)) begin
      irqMask_q <= busReq.wdata[1:0];
    end
  end

  // level interrupt, one cycle behind the status bits
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irqStat_q & irqMask_q);
    end
  end

  // read data valid in the cycle after the strobe only
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdata_q <= 32'h0;
    end else if (!busReq.rd) begin
      rdata_q <= 32'h0;
    end else if (busReq.addr == `OFS_SYS_STAT) begin
      rdata_q <= sysEn_q;
    end else if (busReq.addr == `OFS_PER_STAT) begin
      rdata_q <= perEn_q;
    end else if (busReq.addr == `OFS_OSC_CTRL) begin
      rdata_q <= {16'h0, oscCount_q, 6'h0, oscByp_q, oscEn_q};
    end else if (busReq.addr == `OFS_PWR_STAT) begin
      rdata_q <= {31'h0, stable_q};
    end else if (busReq.addr == `OFS_IRQ_STAT) begin
      rdata_q <= {30'h0, irqStat_q};
    end else if (busReq.addr == `OFS_IRQ_MASK) begin
      rdata_q <= {30'h0, irqMask_q};
    end else begin
      // set/clear registers and unmapped space read zero
      rdata_q <= 32'h0;
    end
  end

  // outputs straight from flops; status writes other than interrupt status clears fall through decode unused
  assign rdata = rdata_q;
  assign clkGates.cpuClk = sysEn_q[`BIT_CPU];
  assign clkGates.hostPortClk = sysEn_q[`BIT_HOST];
  assign clkGates.devicePortClk = sysEn_q[`BIT_DEV];
  assign clkGates.progClockOut = sysEn_q[`BIT_PROG_HI:`BIT_PROG_LO];
  assign clkGates.busClockOut = sysEn_q[`BIT_BUS];
  assign periphClkEn = perEn_q;
  assign mainOscEnable = oscEn_q;
  assign xtalBypass = oscByp_q;
  assign mainOscStable = stable_q;
  assign irq = irq_q;

endmodule

// File: design/clock_gating_cfg.svh
// constants for the clock gating and main oscillator control block
// assumes a byte-addressed register port with 8-bit addresses
`ifndef CLOCK_GATING_CFG_SVH
`define CLOCK_GATING_CFG_SVH

// register byte offsets
`define OFS_SYS_EN 8'h00
`define OFS_SYS_DIS 8'h04
`define OFS_SYS_STAT 8'h08
`define OFS_PER_EN 8'h10
`define OFS_PER_DIS 8'h14
`define OFS_PER_STAT 8'h18
`define OFS_OSC_CTRL 8'h20
`define OFS_PWR_STAT 8'h68
`define OFS_IRQ_STAT 8'h80
`define OFS_IRQ_MASK 8'h84

// system clock bit positions
`define BIT_CPU 0
`define BIT_HOST 6
`define BIT_DEV 7
`define BIT_PROG_LO 8
`define BIT_PROG_HI 11
`define BIT_BUS 16
`define SYS_VALID_MASK 32'h00010fc1
`define PER_VALID_MASK 32'hfffffffc

// oscillator control fields
`define BIT_OSC_EN 0
`define BIT_OSC_BYP 1
`define OSC_CNT_LO 8
`define OSC_CNT_HI 15
`define OSC_CNT_MULT_LOG2 3

// status and interrupt bits
`define BIT_STABLE 0
`define IRQ_STABLE_UP 0
`define IRQ_STABLE_LOST 1

// reset values
`define SYS_STAT_RESET 32'h00000003
`define PER_STAT_RESET 32'h00000000
`define OSC_CTRL_RESET 32'h00000000
`define IRQ_RESET 2'h0

// timing: slow clock derived from the system clock
`define SYS_CLK_HZ 200000000
`define SLOW_CLK_HZ 32768
`define SLOW_DIV_CYCLES (`SYS_CLK_HZ / `SLOW_CLK_HZ)

`endif

// File: design/clock_gating_pkg.sv
// types shared by the clock gating block and its users
// assumes the constants header is included by the design file
package clock_gating_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;

  typedef struct packed {
    logic cpuClk;
    logic hostPortClk;
    logic devicePortClk;
    logic [3:0] progClockOut;
    logic busClockOut;
  } clk_gates_s;

  typedef enum logic [1:0] {
    OSC_OFF = 2'b00,
    OSC_STARTING = 2'b01,
    OSC_STABLE = 2'b10,
    OSC_BYPASSED = 2'b11
  } osc_state_e;

endpackage

// File: verification/clock_gating_and_main_osc_ctrl_tb.sv
// self-checking bench for the clock gating block over its register port
// assumes the constants header is on the include path
`timescale 1ns/1ps
`include "clock_gating_cfg.svh"
module clock_gating_and_main_osc_ctrl_tb
  import clock_gating_pkg::*;
;
  logic sys_clk;
  logic reset;
  bus_req_s busReq;
  logic [31:0] rdata;
  logic [31:0] periphClkEn;
  clk_gates_s clkGates;
  logic mainOscEnable;
  logic xtalBypass;
  logic mainOscStable;
  logic irq;
  int bad_count;
  int checks_done;
  int n;

  // slow tick every 4 cycles keeps the start-up wait short
  clock_gating_and_main_osc_ctrl #(.SLOW_DIV(4)) dut (
    .sys_clk(sys_clk), .reset(reset), .busReq(busReq), .rdata(rdata), .clkGates(clkGates),
    .periphClkEn(periphClkEn), .mainOscEnable(mainOscEnable), .xtalBypass(xtalBypass),
    .mainOscStable(mainOscStable), .irq(irq));

  // 200 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask

  // one-cycle strobes; the next call waits an edge, so no signal is driven twice at once
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    busReq <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk);
    busReq.wr <= 1'b0;
  endtask

  task automatic r(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    busReq <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge sys_clk);
    busReq.rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    #100000;
    bad_count++;
    test_done;
  end

  // main sequence
  initial begin
    busReq = '0;
    reset = 1'b1;
    bad_count = 0;
    checks_done = 0;
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    r(`OFS_SYS_STAT, 32'h1);
    r(`OFS_PER_STAT, 32'h0);
    w(`OFS_SYS_EN, 32'hffffffff);
    r(`OFS_SYS_STAT, 32'h00010fc1);
    chk(32'(clkGates), 32'hff);
    w(`OFS_SYS_DIS, 32'h1);
    r(`OFS_SYS_STAT, 32'h00010fc0);
    w(`OFS_SYS_DIS, 32'h00010f80);
    w(`OFS_SYS_EN, 32'h0);
    r(`OFS_SYS_STAT, 32'h40);
    w(`OFS_SYS_STAT, 32'hffffffff);
    r(`OFS_SYS_STAT, 32'h40);
    r(`OFS_SYS_EN, 32'h0);
    w(`OFS_PER_EN, 32'hffffffff);
    r(`OFS_PER_STAT, 32'hfffffffc);
    w(`OFS_PER_DIS, 32'hf0f0f0f0);
    w(`OFS_PER_STAT, 32'h0);
    r(`OFS_PER_STAT, 32'h0f0f0f0c);
    r(`OFS_PER_DIS, 32'h0);
    chk(periphClkEn, 32'h0f0f0f0c);
    // count 2 means 16 slow ticks, 64 cycles give or take one tick of phase
    w(`OFS_IRQ_MASK, 32'h3);
    w(`OFS_OSC_CTRL, 32'h0201);
    n = 0;
    while (mainOscStable !== 1'b1 && n < 200) begin
      @(posedge sys_clk) #1;
      n++;
    end
    chk(32'(n >= 56 && n <= 72), 32'h1);
    r(`OFS_OSC_CTRL, 32'h0201);
    r(`OFS_IRQ_STAT, 32'h1);
    chk(32'(irq), 32'h1);
    w(`OFS_OSC_CTRL, 32'h0);
    repeat (4) @(posedge sys_clk);
    #1 chk(32'(mainOscStable), 32'h0);
    w(`OFS_OSC_CTRL, 32'h2);
    repeat (3) @(posedge sys_clk);
    #1 chk(32'(mainOscStable), 32'h1);
    r(`OFS_PWR_STAT, 32'h1);
    chk(32'({mainOscEnable, xtalBypass}), 32'h1);
    r(`OFS_IRQ_STAT, 32'h3);
    w(`OFS_IRQ_MASK, 32'h0);
    r(`OFS_IRQ_MASK, 32'h0);
    chk(32'(irq), 32'h0);
    w(`OFS_IRQ_STAT, 32'h3);
    w(`OFS_IRQ_MASK, 32'h3);
    r(`OFS_IRQ_STAT, 32'h0);
    chk(32'(irq), 32'h0);
    r(8'h3c, 32'h0);
    test_done;
  end
endmodule

// File: verification/clock_gating_props.sv
// checker for the clock gating block, watching its ports only
// assumes the constants header is on the include path
`timescale 1ns/1ps
`include "clock_gating_cfg.svh"
module clock_gating_props
  import clock_gating_pkg::*;
#(
  parameter logic [31:0] PERIPH_IMPL = `PER_VALID_MASK,
  parameter int SLOW_DIV = `SLOW_DIV_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire bus_req_s busReq,
  input wire logic [31:0] rdata,
  input wire clk_gates_s clkGates,
  input wire logic [31:0] periphClkEn,
  input wire logic mainOscEnable,
  input wire logic xtalBypass,
  input wire logic mainOscStable,
  input wire logic irq
);
  logic [31:0] sysVec;
  logic [31:0] wd;
  logic [7:0] wa;
  logic [7:0] ra;
  logic [7:0] cntSeen;
  int unsigned waitCyc;

  // status layout rebuilt from the gates; 8'hff is unmapped so it marks no access
  assign sysVec = {15'h0, clkGates.busClockOut, 4'h0, clkGates.progClockOut,
                   clkGates.devicePortClk, clkGates.hostPortClk, 5'h0, clkGates.cpuClk};
  assign wd = busReq.wdata;
  assign wa = busReq.wr ? busReq.addr : 8'hff;
  assign ra = busReq.rd ? busReq.addr : 8'hff;

  // start-up count as last written, and cycles spent waiting for stable with the crystal on
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cntSeen <= 8'h00;
      waitCyc <= 0;
    end else begin
      if (wa == `OFS_OSC_CTRL) begin
        cntSeen <= wd[15:8];
      end
      if (!mainOscEnable || xtalBypass) begin
        waitCyc <= 0;
      end else if (!mainOscStable) begin
        waitCyc <= waitCyc + 1;
      end
    end
  end

  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  // exact next state after each set or clear write, so untouched bits are held too
  a_sys_set: assert property (wa == `OFS_SYS_EN |=>
    sysVec == ($past(sysVec) | ($past(wd) & `SYS_VALID_MASK))) else $error("set write wrong");
  a_sys_clr: assert property (wa == `OFS_SYS_DIS |=>
    sysVec == ($past(sysVec) & ~$past(wd))) else $error("clear write wrong");
  a_per_set: assert property (wa == `OFS_PER_EN |=>
    periphClkEn == ($past(periphClkEn) | ($past(wd) & PERIPH_IMPL & `PER_VALID_MASK))) else $error("periph set wrong");
  a_per_clr: assert property (wa == `OFS_PER_DIS |=>
    periphClkEn == ($past(periphClkEn) & ~$past(wd))) else $error("periph clear wrong");
  a_stat_ro: assert property (wa == `OFS_SYS_STAT || wa == `OFS_PER_STAT |=>
    $stable(sysVec) && $stable(periphClkEn)) else $error("status write had effect");
  a_wo_zero: assert property (ra inside {`OFS_SYS_EN, `OFS_SYS_DIS, `OFS_PER_EN, `OFS_PER_DIS} |=>
    rdata == 32'h0) else $error("write-only read not zero");
  a_sys_read: assert property (ra == `OFS_SYS_STAT |=> rdata == $past(sysVec))
    else $error("system status read wrong");
  a_per_read: assert property (ra == `OFS_PER_STAT |=> rdata == $past(periphClkEn))
    else $error("periph status read wrong");
  a_osc_bits: assert property (wa == `OFS_OSC_CTRL |=>
    mainOscEnable == $past(wd[0]) && xtalBypass == $past(wd[1])) else $error("osc bits wrong");
  a_no_early: assert property ($rose(mainOscStable) |-> mainOscEnable || xtalBypass)
    else $error("stable with oscillator off");
  a_start_wait: assert property ($rose(mainOscStable) && !xtalBypass && cntSeen != 8'h00 |->
    waitCyc >= (32'(cntSeen) * 8 - 1) * SLOW_DIV && waitCyc <= (32'(cntSeen) * 8 + 1) * SLOW_DIV + 4)
    else $error("start-up time wrong");
  a_bypass_fast: assert property (wa == `OFS_OSC_CTRL && wd[1:0] == 2'b10 |->
    ##[1:3] mainOscStable) else $error("bypass not stable");
  a_off_clear: assert property (wa == `OFS_OSC_CTRL && wd[1:0] == 2'b00 |->
    ##[1:4] !mainOscStable) else $error("stable not cleared");

  // main scenarios reached
  c_osc_start: cover property ($rose(mainOscStable) && !xtalBypass);
  c_irq: cover property (irq);
  c_per_clr: cover property (wa == `OFS_PER_DIS);
endmodule

bind clock_gating_and_main_osc_ctrl clock_gating_props #(.PERIPH_IMPL(PERIPH_IMPL), .SLOW_DIV(SLOW_DIV)) props (
  .sys_clk(sys_clk), .reset(reset), .busReq(busReq), .rdata(rdata), .clkGates(clkGates),
  .periphClkEn(periphClkEn), .mainOscEnable(mainOscEnable), .xtalBypass(xtalBypass),
  .mainOscStable(mainOscStable), .irq(irq));
